// ### logic/turn_readout_pkg.sv
// What this block does
// - reading the upper turn register snapshots the lower half and marks it captured
// - position is 21-bit signed, read as 24-bit sign-extended value over two words
// - upper word bits 11:0 hold position bits 20:12 sign-extended to 12 bits
// - lower word bits 11:0 hold position bits 11:0 from the last upper read
// - lower word bit 13 shows captured, and clears once the lower word is read
// - bit 14 of readout words is set when an unmasked error or warning exists
// - upper word bit 13 shows count path, 0 zero crossing, 1 loop path
// - bit 12 of readout words makes the 16-bit word odd parity
// - loop-path count angle offered, with optional hysteresis under a select bit
// - count angle field is 12 bits, one step is 360/4096 degrees
// - count angle word bit 13 is the masked or of both supply-low flags
// - unlock code field bits 15:8 accepts writes and always reads zero
// - memory writes and special actions are refused unless unlocked
// - key register bit 0 reads one exactly while unlocked
package turn_readout_pkg;

	localparam int ADDR_W = 8;
	localparam int FIELD_W = 12;
	localparam int POS_W = 21;
	localparam int EVT_W = 4;

	// register indices; byte address is four times the index
	localparam logic [5:0] IDX_TURN_UPPER = 6'h36;
	localparam logic [5:0] IDX_TURN_LOWER = 6'h38;
	localparam logic [5:0] IDX_LOOP_ANGLE = 6'h3A;
	localparam logic [5:0] IDX_UNLOCK_KEY = 6'h3C;
	localparam logic [5:0] IDX_IRQ_STATUS = 6'h3E;
	localparam logic [5:0] IDX_IRQ_MASK = 6'h3F;

	localparam int BIT_ERR = 14;
	localparam int BIT_FLAG = 13;
	localparam int BIT_PAR = 12;
	localparam int KEY_LANE = 1;

	localparam logic [7:0] KEY_CODE_1 = 8'h27;
	localparam logic [7:0] KEY_CODE_2 = 8'h81;
	localparam logic [7:0] KEY_CODE_3 = 8'h1F;
	localparam logic [7:0] KEY_CODE_4 = 8'h77;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	localparam int EVT_UNLOCK = 0;
	localparam int EVT_KEY_FAIL = 1;
	localparam int EVT_REFUSED = 2;
	localparam int EVT_CAPTURE = 3;

	typedef enum logic [2:0] {
		KEY_IDLE,
		KEY_GOT1,
		KEY_GOT2,
		KEY_GOT3,
		KEY_OPEN
	} key_step_t;

	typedef struct packed {
		logic [POS_W-1:0] turn_delta;
		logic [FIELD_W-1:0] pll_angle;
		logic [FIELD_W-1:0] hys_angle;
		logic count_source_config;
		logic count_hysteresis_select;
		logic [15:0] err_status;
		logic [15:0] err_mask;
		logic uv_analog;
		logic uv_digital;
		logic uv_mask;
	} sensor_in_t;

	typedef struct packed {
		logic [ADDR_W-1:0] awaddr;
		logic aw_held;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic w_held;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
		logic [FIELD_W-1:0] lower_latch;
		logic captured;
		key_step_t key_step;
		logic [EVT_W-1:0] irq_status;
		logic [EVT_W-1:0] irq_mask;
	} state_t;

	localparam state_t STATE_RESET = '0;

endpackage

// ### logic/turn_count_readout_and_unlock.sv
// Decided for this implementation: the AXI4-Lite register port.
`timescale 1ns/10ps
`default_nettype none
module turn_count_readout_and_unlock
	import turn_readout_pkg::*;
(
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite write address
	input wire logic [ADDR_W-1:0] awaddr,
	input wire logic [2:0] awprot,
	input wire logic awvalid,
	output logic awready,
	// axi4-lite write data and response
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// axi4-lite read
	input wire logic [ADDR_W-1:0] araddr,
	input wire logic [2:0] arprot,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// sensor core status
	input wire sensor_in_t sensor,
	// protected actions
	input wire logic nvm_write_req,
	input wire logic special_req,
	output logic nvm_write_en,
	output logic special_en,
	output logic unlocked_indicator,
	// interrupt
	output logic irq
);

	state_t s;
	state_t next_s;

	logic ar_hs;
	logic r_aligned;
	logic [5:0] r_idx;
	logic rd_upper;
	logic rd_lower;
	logic rd_angle;
	logic rd_key;
	logic rd_status;
	logic rd_mask;
	logic do_write;
	logic w_aligned;
	logic [5:0] w_idx;
	logic w_mapped;
	logic key_write;
	logic [7:0] key_code;
	logic [7:0] want_code;
	logic unlocked;
	logic error_summary_flag;
	logic supply_low_flag;
	logic count_path_select;
	logic [FIELD_W-1:0] upper_field;
	logic [FIELD_W-1:0] loop_turn_angle;
	logic [15:0] word_upper;
	logic [15:0] word_lower;
	logic [15:0] word_angle;
	logic [15:0] word_key;
	logic [EVT_W-1:0] events;
	logic [EVT_W-1:0] w1c;

	function automatic logic [15:0] make_word(
		input logic flag_hi,
		input logic flag_lo,
		input logic [FIELD_W-1:0] field
	);
		logic par;
		par = ~^{flag_hi, flag_lo, field};
		make_word = {1'b0, flag_hi, flag_lo, par, field};
	endfunction

	function automatic logic [7:0] expected_code(input key_step_t step);
		case (step)
			KEY_GOT1: expected_code = KEY_CODE_2;
			KEY_GOT2: expected_code = KEY_CODE_3;
			KEY_GOT3: expected_code = KEY_CODE_4;
			default: expected_code = KEY_CODE_1;
		endcase
	endfunction

	// bus handshakes
	assign awready = !s.aw_held && !s.bvalid;
	assign wready = !s.w_held && !s.bvalid;
	assign arready = !s.rvalid;
	assign bvalid = s.bvalid;
	assign bresp = s.bresp;
	assign rvalid = s.rvalid;
	assign rresp = s.rresp;
	assign rdata = s.rdata;

	// read decode
	assign ar_hs = arvalid && arready;
	assign r_aligned = araddr[1:0] == 2'h0;
	assign r_idx = araddr[ADDR_W-1:2];
	assign rd_upper = ar_hs && r_aligned && r_idx == IDX_TURN_UPPER;
	assign rd_lower = ar_hs && r_aligned && r_idx == IDX_TURN_LOWER;
	assign rd_angle = ar_hs && r_aligned && r_idx == IDX_LOOP_ANGLE;
	assign rd_key = ar_hs && r_aligned && r_idx == IDX_UNLOCK_KEY;
	assign rd_status = ar_hs && r_aligned && r_idx == IDX_IRQ_STATUS;
	assign rd_mask = ar_hs && r_aligned && r_idx == IDX_IRQ_MASK;

	// write decode; both halves are held so either may arrive first
	assign do_write = s.aw_held && s.w_held && !s.bvalid;
	assign w_aligned = s.awaddr[1:0] == 2'h0;
	assign w_idx = s.awaddr[ADDR_W-1:2];
	assign w_mapped = w_aligned && (w_idx == IDX_TURN_UPPER || w_idx == IDX_TURN_LOWER
		|| w_idx == IDX_LOOP_ANGLE || w_idx == IDX_UNLOCK_KEY
		|| w_idx == IDX_IRQ_STATUS || w_idx == IDX_IRQ_MASK);
	assign key_write = do_write && w_aligned && w_idx == IDX_UNLOCK_KEY && s.wstrb[KEY_LANE];
	assign key_code = s.wdata[15:8];
	assign want_code = expected_code(s.key_step);

	// unlock gating
	assign unlocked = s.key_step == KEY_OPEN;
	assign unlocked_indicator = unlocked;
	assign nvm_write_en = nvm_write_req && unlocked;
	assign special_en = special_req && unlocked;

	// readout words
	assign error_summary_flag = |(sensor.err_status & ~sensor.err_mask);
	assign supply_low_flag = (sensor.uv_analog || sensor.uv_digital) && !sensor.uv_mask;
	assign count_path_select = sensor.count_source_config;
	assign upper_field = {{3{sensor.turn_delta[POS_W-1]}}, sensor.turn_delta[POS_W-1:FIELD_W]};
	// hysteresis only changes the loop-path angle, never the plain one
	assign loop_turn_angle = sensor.count_hysteresis_select ? sensor.hys_angle
		: sensor.pll_angle;
	assign word_upper = make_word(error_summary_flag, count_path_select, upper_field);
	assign word_lower = make_word(error_summary_flag, s.captured, s.lower_latch);
	assign word_angle = make_word(error_summary_flag, supply_low_flag, loop_turn_angle);
	assign word_key = {8'h00, 7'h00, unlocked};

	// interrupt sources
	assign events[EVT_UNLOCK] = key_write && s.key_step == KEY_GOT3 && key_code == KEY_CODE_4;
	assign events[EVT_KEY_FAIL] = key_write && key_code != want_code;
	assign events[EVT_REFUSED] = (nvm_write_req || special_req) && !unlocked;
	assign events[EVT_CAPTURE] = rd_upper;
	assign w1c = (do_write && w_aligned && w_idx == IDX_IRQ_STATUS && s.wstrb[0])
		? s.wdata[EVT_W-1:0] : '0;
	assign irq = |(s.irq_status & s.irq_mask);

	always_comb begin
		next_s = s;
		// write channel
		if (awvalid && awready) begin
			next_s.awaddr = awaddr;
			next_s.aw_held = 1'b1;
		end
		if (wvalid && wready) begin
			next_s.wdata = wdata;
			next_s.wstrb = wstrb;
			next_s.w_held = 1'b1;
		end
		if (s.bvalid && bready) begin
			next_s.bvalid = 1'b0;
		end
		if (do_write) begin
			next_s.aw_held = 1'b0;
			next_s.w_held = 1'b0;
			next_s.bvalid = 1'b1;
			next_s.bresp = w_mapped ? RESP_OKAY : RESP_SLVERR;
			if (w_aligned && w_idx == IDX_IRQ_MASK && s.wstrb[0]) begin
				next_s.irq_mask = s.wdata[EVT_W-1:0];
			end
		end
		// unlock sequence; a stray 0x27 counts as a fresh first step
		if (key_write) begin
			if (key_code == want_code && s.key_step != KEY_OPEN) begin
				case (s.key_step)
					KEY_IDLE: next_s.key_step = KEY_GOT1;
					KEY_GOT1: next_s.key_step = KEY_GOT2;
					KEY_GOT2: next_s.key_step = KEY_GOT3;
					KEY_GOT3: next_s.key_step = KEY_OPEN;
					default: next_s.key_step = KEY_IDLE;
				endcase
			end else if (key_code == KEY_CODE_1) begin
				next_s.key_step = KEY_GOT1;
			end else begin
				next_s.key_step = KEY_IDLE;
			end
		end
		// read channel
		if (s.rvalid && rready) begin
			next_s.rvalid = 1'b0;
		end
		if (ar_hs) begin
			next_s.rvalid = 1'b1;
			next_s.rresp = RESP_OKAY;
			next_s.rdata = '0;
			if (rd_upper) begin
				next_s.rdata[15:0] = word_upper;
				next_s.lower_latch = sensor.turn_delta[FIELD_W-1:0];
				next_s.captured = 1'b1;
			end else if (rd_lower) begin
				next_s.rdata[15:0] = word_lower;
				next_s.captured = 1'b0;
			end else if (rd_angle) begin
				next_s.rdata[15:0] = word_angle;
			end else if (rd_key) begin
				next_s.rdata[15:0] = word_key;
			end else if (rd_status) begin
				next_s.rdata[EVT_W-1:0] = s.irq_status;
			end else if (rd_mask) begin
				next_s.rdata[EVT_W-1:0] = s.irq_mask;
			end else begin
				next_s.rresp = RESP_SLVERR;
			end
		end
		// new events win over a same-cycle clear
		next_s.irq_status = (s.irq_status & ~w1c) | events;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s <= STATE_RESET;
		end else begin
			s <= next_s;
		end
	end

	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	AST_CAPTURE_LOWER: assert property (
		rd_upper |=> s.captured && s.lower_latch == $past(sensor.turn_delta[FIELD_W-1:0])
	) else $error("lower half not captured on upper read");

	AST_UPPER_FIELD: assert property (
		rd_upper |=> rvalid && rdata[11:0] == {{3{$past(sensor.turn_delta[20])}},
			$past(sensor.turn_delta[20:12])} && rdata[13] == $past(sensor.count_source_config)
	) else $error("upper word field or path bit wrong");

	AST_LOWER_READ: assert property (
		rd_lower |=> rdata[13] == $past(s.captured) && !s.captured
			&& rdata[11:0] == $past(s.lower_latch)
	) else $error("lower word flag or field wrong");

	AST_ODD_PARITY: assert property (
		(rd_upper || rd_lower || rd_angle) |=> (^rdata[15:0]) && !rdata[15]
	) else $error("readout word parity not odd");

	AST_ERROR_SUMMARY: assert property (
		(rd_upper || rd_lower || rd_angle)
			|=> rdata[14] == $past(|(sensor.err_status & ~sensor.err_mask))
	) else $error("error summary bit wrong");

	AST_LOOP_ANGLE: assert property (
		rd_angle |=> rdata[11:0] == $past(loop_turn_angle)
			&& rdata[13] == $past((sensor.uv_analog || sensor.uv_digital) && !sensor.uv_mask)
	) else $error("loop angle word wrong");

	AST_KEY_READ: assert property (
		rd_key |=> rdata[15:1] == 15'h0000 && rdata[0] == $past(unlocked)
	) else $error("key register readback wrong");

	AST_REFUSE_LOCKED: assert property (
		!unlocked_indicator |-> !nvm_write_en && !special_en
	) else $error("protected action granted while locked");

	AST_BAD_CODE_LOCKS: assert property (
		(key_write && key_code != want_code) |=> !unlocked_indicator [*2]
	) else $error("wrong code did not leave device locked");

	AST_UNLOCK_CAUSE: assert property (
		$rose(unlocked_indicator)
			|-> $past(key_write && key_code == KEY_CODE_4 && s.key_step == KEY_GOT3)
	) else $error("unlocked without final code");

	AST_READ_ANSWER: assert property (
		ar_hs |=> rvalid
	) else $error("read not answered next cycle");

	AST_READ_DONE: assert property (
		rvalid && rready |=> !rvalid
	) else $error("read answer stayed after it was taken");

	AST_READY_AFTER_READ: assert property (
		rvalid && rready |=> arready
	) else $error("read address not ready after answer taken");

	AST_READ_OKAY: assert property (
		(rd_upper || rd_lower || rd_angle || rd_key)
			|=> rresp == RESP_OKAY && rdata[31:16] == 16'h0000
	) else $error("mapped read answered wrongly");

	AST_UNALIGNED_READ: assert property (
		ar_hs && araddr[1:0] != 2'h0 |=> rresp == RESP_SLVERR && rdata == 32'h00000000
	) else $error("unaligned read not refused");

	AST_UNMAPPED_READ: assert property (
		ar_hs && araddr == 8'h00 |=> rresp == RESP_SLVERR && rdata == 32'h00000000
	) else $error("unmapped read not refused");

	AST_STATUS_READ: assert property (
		rd_status |=> rdata[31:EVT_W] == '0 && rdata[EVT_W-1:0] == $past(s.irq_status)
	) else $error("status readback wrong");

	AST_MASK_READ: assert property (
		rd_mask |=> rdata[31:EVT_W] == '0 && rdata[EVT_W-1:0] == $past(s.irq_mask)
	) else $error("mask readback wrong");

	AST_WRITE_ANSWER: assert property (
		awvalid && awready && wvalid && wready |=> !bvalid ##1 bvalid
	) else $error("write not answered two cycles after both halves");

	AST_WRITE_DONE: assert property (
		bvalid && bready |=> !bvalid
	) else $error("write answer stayed after it was taken");

	AST_READY_AFTER_WRITE: assert property (
		bvalid && bready |=> awready && wready
	) else $error("write channels not ready after answer taken");

	AST_UNALIGNED_WRITE: assert property (
		do_write && s.awaddr[1:0] != 2'h0 |=> bresp == RESP_SLVERR
	) else $error("unaligned write not refused");

	AST_LATCH_HOLD: assert property (
		!rd_upper |=> $stable(s.lower_latch)
	) else $error("lower half changed without upper read");

	AST_CAPTURE_HOLD: assert property (
		!rd_upper && !rd_lower |=> $stable(s.captured)
	) else $error("captured flag changed without a readout");

	AST_KEY_HOLD: assert property (
		!key_write |=> $stable(s.key_step)
	) else $error("unlock step moved without a key write");

	AST_UNLOCK_NEXT: assert property (
		key_write && s.key_step == KEY_GOT3 && key_code == KEY_CODE_4
			|=> unlocked_indicator
	) else $error("final code did not unlock");

	AST_RELOCK: assert property (
		key_write && unlocked |=> !unlocked_indicator
	) else $error("key write while unlocked did not relock");

	AST_ENABLE_FOLLOWS: assert property (
		unlocked_indicator |-> nvm_write_en == nvm_write_req && special_en == special_req
	) else $error("protected action not passed while unlocked");

	// the release edge still resets state, so events seen there are not kept
	AST_EVENT_SETS: assert property (
		aresetn && (|events) |=> (s.irq_status & $past(events)) == $past(events)
	) else $error("event did not set its status bit");

	AST_REFUSE_EVENT: assert property (
		aresetn && (nvm_write_req || special_req) && !unlocked_indicator
			|=> s.irq_status[EVT_REFUSED]
	) else $error("refused request not flagged");

	AST_STATUS_CLEAR: assert property (
		(do_write && w_aligned && w_idx == IDX_IRQ_STATUS && s.wstrb[0])
			|=> (s.irq_status & $past(w1c & ~events)) == '0
	) else $error("status bits not cleared by write of one");

	AST_MASK_WRITE: assert property (
		(do_write && w_aligned && w_idx == IDX_IRQ_MASK && s.wstrb[0])
			|=> s.irq_mask == $past(s.wdata[EVT_W-1:0])
	) else $error("mask write did not land");

endmodule
`default_nettype wire

// ### verif/host_model.sv
`timescale 1ns/10ps
`default_nettype none
module host_model (
	// clock
	input wire logic aclk,
	// write side
	output logic [7:0] awaddr,
	output logic awvalid,
	input wire logic awready,
	output logic [31:0] wdata,
	output logic [3:0] wstrb,
	output logic wvalid,
	input wire logic wready,
	input wire logic [1:0] bresp,
	input wire logic bvalid,
	output logic bready,
	// read side
	output logic [7:0] araddr,
	output logic arvalid,
	input wire logic arready,
	input wire logic [31:0] rdata,
	input wire logic [1:0] rresp,
	input wire logic rvalid,
	output logic rready
);
	initial begin
		{awaddr, awvalid, wdata, wstrb, wvalid, bready, araddr, arvalid, rready} = '0;
	end
	// handshakes judged at the falling edge, so no race with the slave's flops
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
		output logic [1:0] r);
		logic ta, tw, tb;
		int i;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (i = 0; i < 64; i++) begin
			@(negedge aclk);
			ta = awvalid && awready;
			tw = wvalid && wready;
			tb = bvalid;
			r = bresp;
			@(posedge aclk);
			if (ta) awvalid <= 1'b0;
			if (tw) wvalid <= 1'b0;
			if (tb) break;
		end
		bready <= 1'b0;
		if (i == 64) testbench.hang();
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		logic ta, tr;
		int i;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (i = 0; i < 64; i++) begin
			@(negedge aclk);
			ta = arvalid && arready;
			tr = rvalid;
			d = rdata;
			r = rresp;
			@(posedge aclk);
			if (ta) arvalid <= 1'b0;
			if (tr) break;
		end
		rready <= 1'b0;
		if (i == 64) testbench.hang();
	endtask
endmodule
`default_nettype wire

// ### verif/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench
	import turn_readout_pkg::*;
;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata, d;
	logic [3:0] wstrb, sts;
	logic [1:0] bresp, rresp, r;
	logic awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready, nvm_en, spec_en, unl, irq;
	logic nvm_req = 1'b0;
	logic spec_req = 1'b0;
	sensor_in_t sensor = '0;
	integer seed = 32668;
	int err_count = 0;
	int n_compared = 0;
	int kstep = 0;
	logic [20:0] td;
	logic [7:0] codes [4] = '{8'h27, 8'h81, 8'h1F, 8'h77};
	logic [7:0] seq [14] = '{8'h27, 8'h81, 8'h1F, 8'h77, 8'h27, 8'h81, 8'h00, 8'h1F,
		8'h77, 8'h27, 8'h27, 8'h81, 8'h1F, 8'h77};
	initial forever #2 aclk = ~aclk;
	turn_count_readout_and_unlock dut_u (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
		.awprot(3'h0), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
		.wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arprot(3'h0), .arvalid(arvalid), .arready(arready), .rdata(rdata),
		.rresp(rresp), .rvalid(rvalid), .rready(rready), .sensor(sensor),
		.nvm_write_req(nvm_req), .special_req(spec_req), .nvm_write_en(nvm_en),
		.special_en(spec_en), .unlocked_indicator(unl), .irq(irq));
	host_model host_u (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
		.bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			err_count++;
			$display("unexpected %s: expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wrap_up();
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task automatic hang();
		err_count++;
		wrap_up();
	endtask
	function automatic logic [31:0] wd(input logic fl, input logic [11:0] f);
		logic ef;
		ef = |(sensor.err_status & ~sensor.err_mask);
		return {16'h0, 1'b0, ef, fl, ~^{ef, fl, f}, f};
	endfunction
	task automatic readout();
		logic [95:0] v;
		v = {$random(seed), $random(seed), $random(seed)};
		// clear errors half the time so the summary bit is seen low too
		if (v[95]) v[34:19] = 16'h0;
		td = v[81:61];
		@(posedge aclk);
		sensor <= v[81:0];
		host_u.rd(8'hD8, d, r);
		chk("upper", wd(sensor.count_source_config, {{3{td[20]}}, td[20:12]}), d);
		sts[3] = 1'b1;
		@(posedge aclk);
		sensor.turn_delta <= ~td;
		host_u.rd(8'hE0, d, r);
		chk("lower", wd(1'b1, td[11:0]), d);
		host_u.rd(8'hE0, d, r);
		chk("lower again", wd(1'b0, td[11:0]), d);
		host_u.rd(8'hE8, d, r);
		chk("angle", wd((sensor.uv_analog | sensor.uv_digital) & ~sensor.uv_mask,
			sensor.count_hysteresis_select ? sensor.hys_angle : sensor.pll_angle), d);
	endtask
	task automatic key(input logic [7:0] c);
		if (c != codes[kstep % 4]) sts[1] = 1'b1;
		host_u.wr(8'hF0, {16'h0, c, 8'h0}, 4'h2, r);
		chk("key resp", RESP_OKAY, r);
		if (kstep < 4 && c == codes[kstep])
			kstep++;
		else
			kstep = (c == 8'h27) ? 1 : 0;
		if (kstep == 4) sts[0] = 1'b1;
		host_u.rd(8'hF0, d, r);
		chk("key word", {31'h0, kstep == 4}, d);
		@(negedge aclk);
		chk("unlocked", kstep == 4, unl);
		chk("nvm enable", kstep == 4, nvm_en);
		chk("special enable", kstep == 4, spec_en);
	endtask
	task automatic irq_is(input logic e);
		@(negedge aclk);
		chk("irq", e, irq);
	endtask
	initial begin
		repeat (50000) @(posedge aclk);
		hang();
	end
	initial begin
		sts = 4'h0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		host_u.rd(8'hF0, d, r);
		chk("key after reset", 32'h0, d);
		// only unlock and capture events feed the line; the others fire too freely
		host_u.wr(8'hFC, 32'h9, 4'h1, r);
		chk("mask resp", RESP_OKAY, r);
		host_u.rd(8'hFC, d, r);
		chk("mask", 32'h9, d);
		nvm_req <= 1'b1;
		spec_req <= 1'b1;
		sts[2] = 1'b1;
		repeat (20) readout();
		$display("readout test done");
		irq_is(1'b1);
		foreach (seq[j]) key(seq[j]);
		repeat (8) key(8'($random(seed)));
		foreach (codes[j]) key(codes[j]);
		$display("unlock test done");
		host_u.rd(8'hF8, d, r);
		chk("irq status", {28'h0, sts}, d);
		host_u.wr(8'hFC, 32'h0, 4'h1, r);
		irq_is(1'b0);
		host_u.wr(8'hFC, 32'h9, 4'h1, r);
		irq_is(1'b1);
		host_u.wr(8'hF8, 32'hF, 4'h1, r);
		irq_is(1'b0);
		host_u.rd(8'hD9, d, r);
		chk("unaligned resp", RESP_SLVERR, r);
		host_u.rd(8'h00, d, r);
		chk("unmapped resp", RESP_SLVERR, r);
		chk("unmapped data", 32'h0, d);
		host_u.wr(8'hF1, 32'h0, 4'h2, r);
		chk("unaligned write resp", RESP_SLVERR, r);
		host_u.wr(8'h04, 32'h1, 4'h1, r);
		chk("unmapped write resp", RESP_SLVERR, r);
		host_u.wr(8'hD8, 32'hFFFF, 4'h3, r);
		chk("readout write resp", RESP_OKAY, r);
		$display("interrupt and bus test done");
		@(posedge aclk);
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		host_u.rd(8'hF0, d, r);
		chk("key after second reset", 32'h0, d);
		host_u.rd(8'hFC, d, r);
		chk("mask after second reset", 32'h0, d);
		@(negedge aclk);
		chk("nvm after second reset", 1'b0, nvm_en);
		chk("unlocked after second reset", 1'b0, unl);
		irq_is(1'b0);
		$display("reset test done");
		wrap_up();
	end
endmodule
`default_nettype wire
